// *** rtl/asq_pkg.sv ***
// constants shared by the converter sequencer: register indices, field
// positions, reset values, clock divisors and timing counts.
// assumes a 50 MHz system clock; one oscillator period is one clock.
package asq_pkg;

   // ------------------------------------------------------------
   // register indices (byte address is four times the index)
   // ------------------------------------------------------------
   localparam logic [9:0] IDX_PORT_DATA    = 10'h005; // port data, analog pins read low
   localparam logic [9:0] IDX_GLOBAL_IRQ   = 10'h00B; // global_interrupt_control
   localparam logic [9:0] IDX_PERIPH_FLAGS = 10'h00C; // peripheral_flags_one
   localparam logic [9:0] IDX_RESULT       = 10'h01E; // conversion_result
   localparam logic [9:0] IDX_CTRL_MAIN    = 10'h01F; // converter_control_main
   localparam logic [9:0] IDX_PERIPH_EN    = 10'h08C; // peripheral_enables_one
   localparam logic [9:0] IDX_PIN_SETUP    = 10'h09F; // analog_pin_setup

   // ------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------
   localparam int CM_CLK_LO  = 6;  // conv_clock_select, bits 7:6
   localparam int CM_CHAN_LO = 3;  // channel_select, bits 5:3
   localparam int CM_GO      = 2;  // conversion in progress
   localparam int CM_EN      = 0;  // module_enable
   localparam int FLAG_BIT   = 6;  // converter_irq_flag / converter_irq_enable
   localparam int GIE_BIT    = 7;  // global_irq_enable
   localparam int PERIPHERAL_IRQ_ENABLE_BIT   = 6;  // peripheral_irq_enable

   // ------------------------------------------------------------
   // encodings and reset values
   // ------------------------------------------------------------
   localparam logic [1:0] CLK_DIV2      = 2'h0;  // two oscillator periods
   localparam logic [1:0] CLK_DIV8      = 2'h1;  // eight
   localparam logic [1:0] CLK_DIV32     = 2'h2;  // thirty-two
   localparam logic [1:0] CLK_RC        = 2'h3;  // internal rc clock
   localparam logic [3:0] TRIG_MODE     = 4'hB;  // compare mode that starts conversions
   localparam logic [2:0] PIN_CFG_RESET = 3'h0;  // pins 0,1,2,3,5 analog
   localparam logic [5:0] MASK_ALL      = 6'h2F; // pins 0,1,2,3,5 analog
   localparam logic [5:0] MASK_PARTIAL  = 6'h0B; // pins 0,1,3 analog
   localparam logic [5:0] MASK_NONE     = 6'h00; // all digital

   // ------------------------------------------------------------
   // timing
   // ------------------------------------------------------------
   localparam logic [15:0] DIV_2          = 16'h0002;
   localparam logic [15:0] DIV_8          = 16'h0008;
   localparam logic [15:0] DIV_32         = 16'h0020;
   localparam int          CLK_PERIOD_NS  = 20;    // 50 MHz
   localparam int          RC_TAD_NS      = 4000;  // typical rc bit period
   localparam logic [15:0] RC_TAD_CYC     = 16'(RC_TAD_NS / CLK_PERIOD_NS);
   localparam logic [15:0] INSTR_CYC      = 16'h0004; // one instruction cycle
   localparam logic [3:0]  TAD_PER_CONV   = 4'h9;  // sample period plus 8 bits
   localparam logic [3:0]  POST_WAIT_TADS = 4'h2;  // settle after end or abort

   // sequencer states
   typedef enum logic [1:0] {
      ST_IDLE     = 2'b00,  // acquiring when enabled
      ST_RC_DELAY = 2'b01,  // one instruction cycle before rc conversion
      ST_CONVERT  = 2'b10,  // sampling period then bit decisions
      ST_SETTLE   = 2'b11   // two bit periods before next acquisition
   } asq_state_t;

endpackage

// *** rtl/asq_adc_ctrl.sv ***
// sequencer and register file for an 8-bit successive approximation converter.
// assumes an apb master on the register side, an analog core that samples
// while sample_enable is high and settles comp_high within one clock, and
// same-clock sleep and compare-unit signals.
`timescale 1ns/1ps

// Overview of operation
// - pin config field selects analog pins and reference
// - completion loads result, clears busy, sets flag
// - result register keeps value through reset
// - two bit periods before next acquisition
// - conversion lasts nine bit periods
// - clock select picks 2, 8, 32 or rc
// - port data reads zero on analog pins
// - clearing busy aborts, result unchanged
// - after abort in conversion, wait two periods, reacquire
// - rc clock delays start one instruction cycle
// - completion in sleep wakes only if enabled
// - sleep without rc aborts and powers off
// - reset clears control registers, aborts, pins analog
// - compare trigger starts conversion, clears timer
// - disabled module ignores trigger, timer still cleared
// - channel field routes channels zero to seven
// - result formed by successive approximation
module asq_adc_ctrl #(
   parameter logic [15:0] RC_DIV = asq_pkg::RC_TAD_CYC  // rc bit period in clocks
) (
   input  wire logic        clk,
   input  wire logic        reset,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        comp_high,           // analog comparator, same clock
   input  wire logic [5:0]  port_pins,           // pin levels, asynchronous
   input  wire logic        sleep_mode,          // core is asleep
   input  wire logic        compare_trigger,     // special event pulse
   input  wire logic [3:0]  compare_mode_field,  // compare unit mode
   output logic      [5:0]  analog_pin_mask,
   output logic             vref_external,
   output logic      [2:0]  channel_out,
   output logic             sample_enable,
   output logic             module_power,
   output logic      [7:0]  dac_code,
   output logic             wake_request,
   output logic             timer_clear
);

   // ------------------------------------------------------------
   // declarations
   // ------------------------------------------------------------
   asq_pkg::asq_state_t state_ff, nxt_state;   // sequencer state
   logic        gie_ff, peripheral_irq_enable_ff;               // global interrupt bits, stored only
   logic        flag_ff, nxt_flag;             // converter_irq_flag
   logic        irq_en_ff;                     // converter_irq_enable
   logic [7:0]  result_ff;                     // conversion_result, never reset
   logic [1:0]  clksel_ff;                     // conv_clock_select
   logic [2:0]  chan_ff;                       // channel_select
   logic        go_ff, nxt_go;                 // conversion in progress
   logic        enable_ff;                     // module_enable
   logic [2:0]  pincfg_ff;                     // pin_config_field
   logic [5:0]  pin_s1_ff, pin_s2_ff;          // pin synchroniser
   logic [15:0] div_lat_ff, div_cnt_ff;        // bit period divider
   logic [15:0] phase_cyc_ff;                  // clocks spent in current state
   logic [3:0]  tad_idx_ff;                    // bit periods spent in current state
   logic [7:0]  sar_ff, mask_ff;               // trial value and bit under test
   logic [31:0] prdata_ff;
   logic        pready_ff, pslverr_ff;
   logic [5:0]  amask_ff;
   logic        vref_ff, sample_ff, power_ff, wake_ff, tclr_ff;
   logic [2:0]  chan_out_ff;

   // ------------------------------------------------------------
   // pin decode, shared by pin outputs and port reads
   // ------------------------------------------------------------
   // returns {external reference, analog mask}
   function automatic logic [6:0] pin_decode(input logic [2:0] cfg);
      if (cfg[2:1] == 2'b11) begin
         pin_decode = {1'b0, asq_pkg::MASK_NONE};         // all digital
      end else if (cfg[2]) begin
         pin_decode = {cfg[0], asq_pkg::MASK_PARTIAL};    // pins 2 and 5 digital
      end else begin
         pin_decode = {cfg[0], asq_pkg::MASK_ALL};        // odd codes use reference pin
      end
   endfunction

   // ------------------------------------------------------------
   // apb decode
   // ------------------------------------------------------------
   wire [9:0] idx       = paddr[11:2];                    // register index
   wire       aligned   = (paddr[1:0] == 2'b00);
   wire       acc_req   = psel & penable & ~pready_ff;   // first access cycle
   wire       acc_done  = psel & penable & pready_ff;    // completing edge
   wire       wr        = acc_done & pwrite;
   wire [7:0] wd        = pwdata[7:0];
   wire       hit_port  = aligned & (idx == asq_pkg::IDX_PORT_DATA);
   wire       hit_gic   = aligned & (idx == asq_pkg::IDX_GLOBAL_IRQ);
   wire       hit_flags = aligned & (idx == asq_pkg::IDX_PERIPH_FLAGS);
   wire       hit_res   = aligned & (idx == asq_pkg::IDX_RESULT);
   wire       hit_ctrl  = aligned & (idx == asq_pkg::IDX_CTRL_MAIN);
   wire       hit_en    = aligned & (idx == asq_pkg::IDX_PERIPH_EN);
   wire       hit_pins  = aligned & (idx == asq_pkg::IDX_PIN_SETUP);
   wire       known     = hit_port | hit_gic | hit_flags | hit_res | hit_ctrl
                        | hit_en | hit_pins;
   wire       wr_ctrl   = wr & hit_ctrl;

   // read values; unimplemented bits read zero
   wire [7:0] rd_ctrl = {clksel_ff, chan_ff, go_ff, 1'b0, enable_ff};
   wire [7:0] rd_gic  = {gie_ff, peripheral_irq_enable_ff, 6'h00};
   wire [7:0] rd_flag = {1'b0, flag_ff, 6'h00};
   wire [7:0] rd_en   = {1'b0, irq_en_ff, 6'h00};
   wire [7:0] rd_pins = {5'h00, pincfg_ff};
   wire [7:0] rd_port = {2'h0, pin_s2_ff & ~amask_ff};
   wire [7:0] rd_mux  = hit_ctrl  ? rd_ctrl :
                        hit_res   ? result_ff :
                        hit_gic   ? rd_gic :
                        hit_flags ? rd_flag :
                        hit_en    ? rd_en :
                        hit_pins  ? rd_pins :
                        hit_port  ? rd_port : 8'h00;

   // ------------------------------------------------------------
   // start, abort and completion terms
   // ------------------------------------------------------------
   wire trig_hit   = compare_trigger & (compare_mode_field == asq_pkg::TRIG_MODE);
   wire power_down = sleep_mode & (clksel_ff != asq_pkg::CLK_RC);
   wire sw_go_set  = wr_ctrl & wd[asq_pkg::CM_GO] & enable_ff;
   wire sw_go_clr  = wr_ctrl & ~wd[asq_pkg::CM_GO];
   wire trig_go    = trig_hit & enable_ff;
   wire go_set     = (sw_go_set | trig_go) & ~power_down;
   wire busy       = (state_ff == asq_pkg::ST_CONVERT) | (state_ff == asq_pkg::ST_RC_DELAY);
   // an abort that meets a fresh start in the same cycle is dropped
   wire abort      = busy & ~go_set & (sw_go_clr | power_down | ~enable_ff);
   wire tick       = (div_cnt_ff == div_lat_ff - 16'h0001);
   wire conv_tick  = (state_ff == asq_pkg::ST_CONVERT) & tick & ~abort;
   wire done       = conv_tick & (tad_idx_ff == asq_pkg::TAD_PER_CONV - 4'h1);
   // keep the trial bit if the input is at or above the trial level; the comparator
   // is read directly, as two synchroniser flops would outlast a two-clock bit period
   wire [7:0] resolved = comp_high ? sar_ff : (sar_ff & ~mask_ff);
   wire [6:0] pin_dec  = pin_decode(pincfg_ff);
   wire       state_chg = (nxt_state != state_ff);

   // bit period select; frozen while converting or settling
   wire [15:0] div_sel = (clksel_ff == asq_pkg::CLK_DIV2)  ? asq_pkg::DIV_2 :
                         (clksel_ff == asq_pkg::CLK_DIV8)  ? asq_pkg::DIV_8 :
                         (clksel_ff == asq_pkg::CLK_DIV32) ? asq_pkg::DIV_32 : RC_DIV;

   // ------------------------------------------------------------
   // sequencer next state
   // ------------------------------------------------------------
   always_comb begin
      nxt_state = state_ff;
      unique case (state_ff)
         asq_pkg::ST_IDLE: begin
            if (go_ff & enable_ff & ~power_down) begin
               // rc clock lets the core fall asleep before sampling ends
               nxt_state = (clksel_ff == asq_pkg::CLK_RC) ? asq_pkg::ST_RC_DELAY
                                                          : asq_pkg::ST_CONVERT;
            end
         end
         asq_pkg::ST_RC_DELAY: begin
            if (abort) begin
               nxt_state = asq_pkg::ST_IDLE;
            end else if (phase_cyc_ff == asq_pkg::INSTR_CYC - 16'h0001) begin
               nxt_state = asq_pkg::ST_CONVERT;
            end
         end
         asq_pkg::ST_CONVERT: begin
            if (abort | done) begin
               nxt_state = asq_pkg::ST_SETTLE;
            end
         end
         asq_pkg::ST_SETTLE: begin
            if (tick & (tad_idx_ff == asq_pkg::POST_WAIT_TADS - 4'h1)) begin
               nxt_state = asq_pkg::ST_IDLE;
            end
         end
      endcase
   end

   // set wins over every clear
   assign nxt_go   = go_set | (go_ff & ~(sw_go_clr | done | power_down | ~enable_ff));
   assign nxt_flag = done | ((wr & hit_flags) ? wd[asq_pkg::FLAG_BIT] : flag_ff);

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   // control registers, all cleared by reset
   always_ff @(posedge clk) begin
      if (reset) begin
         gie_ff    <= 1'b0;
         peripheral_irq_enable_ff   <= 1'b0;
         flag_ff   <= 1'b0;
         irq_en_ff <= 1'b0;
         clksel_ff <= asq_pkg::CLK_DIV2;
         chan_ff   <= 3'h0;
         go_ff     <= 1'b0;
         enable_ff <= 1'b0;
         pincfg_ff <= asq_pkg::PIN_CFG_RESET;
      end else begin
         flag_ff <= nxt_flag;
         go_ff   <= nxt_go;
         if (wr & hit_gic) begin
            gie_ff  <= wd[asq_pkg::GIE_BIT];
            peripheral_irq_enable_ff <= wd[asq_pkg::PERIPHERAL_IRQ_ENABLE_BIT];
         end
         if (wr & hit_en) begin
            irq_en_ff <= wd[asq_pkg::FLAG_BIT];
         end
         if (wr_ctrl) begin
            clksel_ff <= wd[asq_pkg::CM_CLK_LO +: 2];
            chan_ff   <= wd[asq_pkg::CM_CHAN_LO +: 3];
            enable_ff <= wd[asq_pkg::CM_EN];
         end
         if (wr & hit_pins) begin
            pincfg_ff <= wd[2:0];
         end
      end
   end

   // result: no reset on purpose, survives every reset
   always_ff @(posedge clk) begin
      if (done) begin
         result_ff <= resolved;
      end else if (wr & hit_res) begin
         result_ff <= wd;
      end
   end

   // two-stage synchroniser for the asynchronous pin levels
   always_ff @(posedge clk) begin
      pin_s1_ff <= port_pins;
      pin_s2_ff <= pin_s1_ff;
   end

   // state, divider and phase counters restart on each state change
   always_ff @(posedge clk) begin
      if (reset) begin
         state_ff     <= asq_pkg::ST_IDLE;
         div_lat_ff   <= asq_pkg::DIV_2;
         div_cnt_ff   <= 16'h0000;
         phase_cyc_ff <= 16'h0000;
         tad_idx_ff   <= 4'h0;
      end else begin
         state_ff     <= nxt_state;
         div_lat_ff   <= ((state_ff == asq_pkg::ST_IDLE) | (state_ff == asq_pkg::ST_RC_DELAY))
                         ? div_sel : div_lat_ff;
         div_cnt_ff   <= (state_chg | tick) ? 16'h0000 : div_cnt_ff + 16'h0001;
         phase_cyc_ff <= state_chg ? 16'h0000 : phase_cyc_ff + 16'h0001;
         tad_idx_ff   <= state_chg ? 4'h0 : (tick ? tad_idx_ff + 4'h1 : tad_idx_ff);
      end
   end

   // successive approximation, one decision per bit period
   always_ff @(posedge clk) begin
      if (reset) begin
         sar_ff  <= 8'h00;
         mask_ff <= 8'h00;
      end else if (conv_tick & (tad_idx_ff == 4'h0)) begin
         sar_ff  <= 8'h80;                            // msb trial first
         mask_ff <= 8'h80;
      end else if (conv_tick) begin
         sar_ff  <= resolved | (mask_ff >> 1);
         mask_ff <= mask_ff >> 1;
      end
   end

   // apb answer: one wait state, error for unmapped addresses
   always_ff @(posedge clk) begin
      if (reset) begin
         pready_ff  <= 1'b0;
         pslverr_ff <= 1'b0;
         prdata_ff  <= 32'h0000_0000;
      end else begin
         pready_ff  <= acc_req;
         pslverr_ff <= acc_req & ~known;
         if (acc_req) begin
            prdata_ff <= pwrite ? 32'h0000_0000 : {24'h00_0000, rd_mux};
         end
      end
   end

   // pin, analog core and event outputs
   always_ff @(posedge clk) begin
      if (reset) begin
         amask_ff    <= asq_pkg::MASK_ALL;    // pins 0,1,2,3,5 analog
         vref_ff     <= 1'b0;
         chan_out_ff <= 3'h0;
         sample_ff   <= 1'b0;
         power_ff    <= 1'b0;
         wake_ff     <= 1'b0;
         tclr_ff     <= 1'b0;
      end else begin
         amask_ff    <= pin_dec[5:0];
         vref_ff     <= pin_dec[6];
         chan_out_ff <= chan_ff;
         // acquire in idle, in the rc start delay and during the first bit period of a conversion
         sample_ff   <= enable_ff & ~power_down & ((state_ff == asq_pkg::ST_IDLE)
                        | (state_ff == asq_pkg::ST_RC_DELAY)
                        | ((state_ff == asq_pkg::ST_CONVERT) & (tad_idx_ff == 4'h0)));
         power_ff    <= enable_ff & ~power_down;
         wake_ff     <= done & sleep_mode & irq_en_ff;
         tclr_ff     <= trig_hit;
      end
   end

   assign prdata          = prdata_ff;
   assign pready          = pready_ff;
   assign pslverr         = pslverr_ff;
   assign analog_pin_mask = amask_ff;
   assign vref_external   = vref_ff;
   assign channel_out     = chan_out_ff;
   assign sample_enable   = sample_ff;
   assign module_power    = power_ff;
   assign dac_code        = sar_ff;
   assign wake_request    = wake_ff;
   assign timer_clear     = tclr_ff;

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   a_pins_all_digital: assert property (
      (pincfg_ff[2:1] == 2'b11) |=> (amask_ff == 6'h00) && !vref_ff)
      else $error("digital config left analog pins");
   a_done_flags: assert property (
      done |=> flag_ff && (result_ff == $past(resolved)) && (state_ff == asq_pkg::ST_SETTLE))
      else $error("completion did not load result and flag");
   a_conv_length: assert property (
      done |-> (phase_cyc_ff == 9 * div_lat_ff - 1))
      else $error("conversion not nine bit periods");
   a_settle_length: assert property (
      (state_ff == asq_pkg::ST_SETTLE && nxt_state == asq_pkg::ST_IDLE)
      |-> (phase_cyc_ff == 2 * div_lat_ff - 1))
      else $error("settle not two bit periods");
   a_abort_keeps: assert property (
      (abort && !(wr && hit_res)) |=> $stable(result_ff) && (state_ff == asq_pkg::ST_SETTLE
                                      || state_ff == asq_pkg::ST_IDLE))
      else $error("abort changed result");
   a_rc_delay_len: assert property (
      (state_ff == asq_pkg::ST_RC_DELAY ##1 state_ff == asq_pkg::ST_CONVERT)
      |-> $past(phase_cyc_ff) == 3)
      else $error("rc start delay wrong");
   a_sleep_wake: assert property (
      done && sleep_mode |=> wake_request == $past(irq_en_ff))
      else $error("wake does not follow irq enable");
   a_sleep_off: assert property (
      (power_down && enable_ff && !wr_ctrl) |=> !module_power && enable_ff && !busy)
      else $error("sleep did not power off");
   a_trig_start: assert property (
      (trig_hit && enable_ff && !power_down) |=> go_ff && timer_clear)
      else $error("trigger did not start");
   a_trig_ignore: assert property (
      (trig_hit && !enable_ff && !go_ff && !wr_ctrl) |=> !go_ff && timer_clear)
      else $error("disabled trigger misbehaved");
   a_port_analog: assert property (
      (acc_req && !pwrite && hit_port) |=> (prdata[5:0] & analog_pin_mask) == 6'h00)
      else $error("analog pin read nonzero");
   a_msb_first: assert property (
      (conv_tick && tad_idx_ff == 4'h0) |=> dac_code == 8'h80 ##1 !sample_enable)
      else $error("trial did not start at msb");
   a_reset_state: assert property (@(posedge clk) disable iff (1'b0)
      reset |=> state_ff == asq_pkg::ST_IDLE && !enable_ff && amask_ff == 6'h2F)
      else $error("reset values wrong");

   c_complete:   cover property (done ##[1:100] wake_request);
   c_abort:      cover property (abort ##1 state_ff == asq_pkg::ST_SETTLE);
   c_trigger:    cover property (trig_go ##[1:20] state_ff == asq_pkg::ST_CONVERT);
   c_rc_convert: cover property (state_ff == asq_pkg::ST_RC_DELAY ##[1:8]
                                 state_ff == asq_pkg::ST_CONVERT);

endmodule

// *** test/asq_analog_model.sv ***
// sample-and-hold and comparator standing in for the analog core.
// assumes the sequencer holds dac_code steady across each bit period.
`timescale 1ns/1ps
module asq_analog_model (
   input  wire logic       clk,
   input  wire logic       sample_enable,
   input  wire logic [7:0] vin,
   input  wire logic [7:0] dac_code,
   output logic            comp_high
);
   logic [7:0] held_ff; // charge on the hold capacitor

   // track while sampling, freeze once the bit decisions begin
   always_ff @(posedge clk) begin
      if (sample_enable) held_ff <= vin;
   end
   // ideal comparator, so the result equals the held input exactly
   assign comp_high = (held_ff >= dac_code);
endmodule

// *** test/asq_adc_ctrl_test.sv ***
// self-checking bench for the converter sequencer over apb.
// assumes the analog model on the far side; rc bit period shortened.
`timescale 1ns/1ps
module asq_adc_ctrl_test;
   logic        clk, reset, psel, penable, pwrite, pready, pslverr, comp_high;
   logic        sleep_mode, compare_trigger, vref_external, sample_enable;
   logic        module_power, timer_clear, wake_request;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [5:0]  port_pins, analog_pin_mask;
   logic [7:0]  vin, dac_code;
   logic [3:0]  compare_mode_field;
   logic [2:0]  channel_out;
   int          fails = 0, total_checks = 0, i, wakes = 0;
   logic [6:0]  pin_tab [8] = '{7'h2F, 7'h6F, 7'h2F, 7'h6F, 7'h0B, 7'h4B, 7'h00, 7'h00};
   logic [7:0]  vals [4] = '{8'hA5, 8'h00, 8'hFF, 8'h5A};

   // bit periods sit far below the legal range here to keep runs short
   asq_adc_ctrl #(.RC_DIV(16'h0006)) dut (.clk, .reset, .psel, .penable, .pwrite,
      .paddr, .pwdata, .prdata, .pready, .pslverr, .comp_high, .port_pins, .sleep_mode,
      .compare_trigger, .compare_mode_field, .analog_pin_mask, .vref_external,
      .channel_out, .sample_enable, .module_power, .dac_code, .wake_request,
      .timer_clear);
   asq_analog_model core (.clk, .sample_enable, .vin, .dac_code, .comp_high);

   // count wake pulses, each one clock long
   always @(posedge clk) begin
      if (wake_request === 1'b1) wakes++;
   end

   // 50 MHz clock
   initial begin
      clk = 0;
      forever #10 clk = ~clk;
   end

   task automatic test_done;
      $display("checks %0d failures %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      total_checks++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED at %0t: %s got %h", $time, what, got);
      end
   endtask
   // one apb transfer; request held until pready is seen high
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n = 0;
      @(posedge clk);
      psel <= 1; pwrite <= wr; paddr <= a; pwdata <= d;
      @(posedge clk);
      penable <= 1;
      do begin @(posedge clk); n++; end while (pready !== 1'b1 && n < 20);
      rd = pslverr ? 32'hFFFF_FFFF : prdata;
      psel <= 0; penable <= 0;
      if (n >= 20) begin fails++; test_done(); end
   endtask
   // poll until the busy bit drops, bounded
   task automatic wait_done;
      int n = 0;
      do begin apb(0, 12'h07C, 0); n++; end while (rd[2] !== 1'b0 && n < 200);
      if (n >= 200) begin fails++; test_done(); end
   endtask

   initial begin
      reset = 1; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0; vin = 0;
      sleep_mode = 0; compare_trigger = 0; compare_mode_field = 0; port_pins = 6'h3F;
      repeat (3) @(posedge clk);
      reset <= 0;
      apb(0, 12'h07C, 0); chk(rd, 0, "ctrl reset");
      chk(analog_pin_mask, 6'h2F, "mask reset");
      apb(0, 12'h014, 0); chk(rd, 32'h10, "port analog");
      apb(0, 12'h100, 0); chk(rd, 32'hFFFF_FFFF, "unmapped");
      for (i = 0; i < 8; i++) begin
         apb(1, 12'h27C, 32'(i));
         repeat (2) @(posedge clk);
         chk({vref_external, analog_pin_mask}, pin_tab[i], "pin config");
      end
      apb(0, 12'h014, 0); chk(rd, 32'h3F, "port digital");
      $display("test pins done");
      for (i = 0; i < 4; i++) begin
         vin <= vals[i];
         apb(1, 12'h07C, 32'(i * 64 + 8'h11));
         repeat (2) @(posedge clk);
         chk(channel_out, 3'h2, "channel");
         apb(1, 12'h07C, 32'(i * 64 + 8'h15));
         wait_done;
         apb(0, 12'h078, 0); chk(rd, vals[i], "result");
         apb(0, 12'h030, 0); chk(rd[6], 1, "flag");
         apb(1, 12'h030, 0);
      end
      $display("test convert done");
      vin <= 8'h33;
      apb(1, 12'h07C, 8'h95);
      apb(1, 12'h07C, 8'h91);
      repeat (30) @(posedge clk);
      chk(sample_enable, 0, "settle");
      repeat (40) @(posedge clk);
      chk(sample_enable, 1, "reacquire");
      apb(0, 12'h078, 0); chk(rd, 8'h5A, "abort keeps");
      apb(0, 12'h030, 0); chk(rd[6], 0, "abort no flag");
      $display("test abort done");
      vin <= 8'h77; compare_mode_field <= 4'hB;
      apb(1, 12'h07C, 8'h01);
      @(posedge clk) compare_trigger <= 1;
      @(posedge clk) compare_trigger <= 0;
      @(posedge clk) chk(timer_clear, 1, "timer clear");
      wait_done;
      apb(0, 12'h078, 0); chk(rd, 8'h77, "trigger result");
      apb(1, 12'h07C, 8'h00);
      @(posedge clk) compare_trigger <= 1;
      @(posedge clk) compare_trigger <= 0;
      @(posedge clk) chk(timer_clear, 1, "timer clear off");
      apb(0, 12'h07C, 0); chk(rd, 0, "trigger ignored");
      $display("test trigger done");
      vin <= 8'h12;
      apb(1, 12'h07C, 8'h01);
      apb(1, 12'h07C, 8'h05);
      @(posedge clk) sleep_mode <= 1;
      repeat (3) @(posedge clk);
      chk(module_power, 0, "sleep power off");
      apb(0, 12'h07C, 0); chk(rd, 1, "enable kept, go cleared");
      apb(0, 12'h078, 0); chk(rd, 8'h77, "sleep abort keeps");
      vin <= 8'hC3;
      apb(1, 12'h230, 32'h40);
      apb(1, 12'h07C, 32'hC1);
      apb(1, 12'h07C, 32'hC5);
      wait_done;
      chk(wakes, 1, "rc sleep wake");
      apb(0, 12'h078, 0); chk(rd, 8'hC3, "rc sleep result");
      apb(1, 12'h230, 0);
      apb(1, 12'h07C, 32'hC5);
      wait_done; chk(rd, 32'hC1, "asleep enable kept");
      repeat (2) @(posedge clk);
      chk(wakes, 1, "no wake");
      sleep_mode <= 0;
      reset <= 1;
      repeat (2) @(posedge clk);
      reset <= 0;
      apb(0, 12'h078, 0); chk(rd, 8'hC3, "result kept");
      apb(0, 12'h07C, 0); chk(rd, 0, "ctrl after reset");
      chk(analog_pin_mask, 6'h2F, "pins analog after reset");
      $display("test sleep and reset done");
      test_done();
   end
endmodule
